// file: src/dsg_pkg.sv
// constants and types for deep-sleep port gating and software reset control
package dsg_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;
   localparam int PORT_N = 5;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_SOFTWARE_RESET_CTRL_0      = 12'h040;
   localparam logic [ADDR_W-1:0] OFF_RUN_MODE_CLOCK_CONFIG      = 12'h060;
   localparam logic [ADDR_W-1:0] OFF_RUN_PORT_CLOCK_GATE        = 12'h108;
   localparam logic [ADDR_W-1:0] OFF_SLEEP_PORT_CLOCK_GATE      = 12'h118;
   localparam logic [ADDR_W-1:0] OFF_DEEP_SLEEP_PORT_CLOCK_GATE = 12'h128;

   // port gating fields
   localparam int PORT_A_CLOCK_ENABLE = 0;
   localparam int PORT_B_CLOCK_ENABLE = 1;
   localparam int PORT_C_CLOCK_ENABLE = 2;
   localparam int PORT_D_CLOCK_ENABLE = 3;
   localparam int PORT_E_CLOCK_ENABLE = 4;
   localparam logic [DATA_W-1:0] PORT_GATE_WMASK = 32'h0000001F;
   localparam logic [DATA_W-1:0] PORT_GATE_RESET = 32'h00000000;

   // software reset fields
   localparam int WATCHDOG_RESET_CTRL = 3;
   localparam int ADC0_RESET_CTRL     = 16;
   localparam logic [DATA_W-1:0] SW_RESET_WMASK = 32'h00010008;
   localparam logic [DATA_W-1:0] SW_RESET_RESET = 32'h00000000;

   // run-mode clock configuration fields
   localparam int AUTO_CLOCK_GATING_SELECT = 0;
   localparam logic [DATA_W-1:0] RUN_CFG_WMASK = 32'h00000001;
   localparam logic [DATA_W-1:0] RUN_CFG_RESET = 32'h00000000;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      DSG_RUN,
      DSG_SLEEP,
      DSG_DEEP
   } dsg_power_mode_t;

endpackage

// file: src/dsg_mode_gate.sv
// selects the port clock enables that apply in the current power mode
`timescale 1ns/1ns
module dsg_mode_gate #(
   parameter int PORT_N = 5
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire dsg_pkg::dsg_power_mode_t power_mode,
   input  wire logic                     auto_gating,
   input  wire logic [PORT_N-1:0]        run_gate,
   input  wire logic [PORT_N-1:0]        sleep_gate,
   input  wire logic [PORT_N-1:0]        deep_gate,
   output logic      [PORT_N-1:0]        port_clk_en
);
   import dsg_pkg::*;

   logic [PORT_N-1:0] next_port_clk_en;

   // without auto gating the run set stays in force in every mode
   always_comb begin
      next_port_clk_en = run_gate;
      case (power_mode)
         DSG_RUN:   next_port_clk_en = run_gate;
         DSG_SLEEP: next_port_clk_en = auto_gating ? sleep_gate : run_gate; // [R4] [R5]
         DSG_DEEP:  next_port_clk_en = auto_gating ? deep_gate : run_gate;  // [R4] [R5] [R1]
         default:   next_port_clk_en = run_gate;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_clk_en <= '0; // [R3]
      end else begin
         port_clk_en <= next_port_clk_en;
      end
   end

endmodule

// file: src/dsg_ctrl.sv
// system-control slice: port clock gating sets and software reset register
`timescale 1ns/1ns

// Contract
// R1: deep-sleep gate register holds enables for ports A..E at bits 0..4.
// R2: access to a port whose clock is gated off returns a bus fault.
// R3: all port enables in the deep-sleep gate register reset to zero.
// R4: separate run, sleep and deep-sleep gate sets; the current mode's set applies.
// R5: sleep and deep-sleep sets apply only while auto clock gating is selected.
// R6: deep-sleep gate bits 31:5 read zero and ignore writes.
// R7: software keeps reserved bits intact across read-modify-write.
// R8: software reset writes are masked by the first capabilities register.
// R9: software reset bit 16 is read/write reset control for converter 0.
// R10: bit 3 resets the watchdog; bits 31:17, 15:4, 2:0 read zero.
// R11: software reset register resets to all zeros.
// R12: a set reset bit holds its unit in reset; clearing releases it.
module dsg_ctrl #(
   parameter int PORT_N = dsg_pkg::PORT_N
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // write address channel
   input  wire logic [dsg_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic [2:0]                  s_axi_awprot,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   // write data channel
   input  wire logic [dsg_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [dsg_pkg::STRB_W-1:0]  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   // write response channel
   output logic      [1:0]                  s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // read address channel
   input  wire logic [dsg_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic [2:0]                  s_axi_arprot,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   // read data channel
   output logic      [dsg_pkg::DATA_W-1:0]  s_axi_rdata,
   output logic      [1:0]                  s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // system side
   input  wire dsg_pkg::dsg_power_mode_t    power_mode,
   input  wire logic [dsg_pkg::DATA_W-1:0]  device_capabilities_first,
   input  wire logic [PORT_N-1:0]           port_access_req,
   output logic      [PORT_N-1:0]           port_clk_en,
   output logic      [PORT_N-1:0]           port_access_fault,
   output logic                             adc0_reset_hold,
   output logic                             watchdog_reset_hold
);
   import dsg_pkg::*;

   // registers
   logic [DATA_W-1:0] software_reset_ctrl_0;
   logic [DATA_W-1:0] run_mode_clock_config;
   logic [DATA_W-1:0] run_port_clock_gate;
   logic [DATA_W-1:0] sleep_port_clock_gate;
   logic [DATA_W-1:0] deep_sleep_port_clock_gate;

   // write path state
   logic [ADDR_W-1:0] wr_addr;
   logic              wr_addr_held;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;
   logic              wr_data_held;
   logic              wr_fire;
   logic              wr_hit;

   // read path
   logic [DATA_W-1:0] rd_value;
   logic              rd_hit;
   logic              rd_fire;

   // merge new data into old under byte strobes, keeping only writable bits
   function automatic logic [DATA_W-1:0] merge_write(
      input logic [DATA_W-1:0] old_value,
      input logic [DATA_W-1:0] new_value,
      input logic [STRB_W-1:0] strb,
      input logic [DATA_W-1:0] wmask
   );
      logic [DATA_W-1:0] lanes;
      lanes = '0;
      for (int i = 0; i < STRB_W; i++) begin
         lanes[i*8 +: 8] = {8{strb[i]}};
      end
      merge_write = ((old_value & ~lanes) | (new_value & lanes)) & wmask;
   endfunction

   // address decode shared by the read and write paths
   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      case (addr)
         OFF_SOFTWARE_RESET_CTRL_0:      is_mapped = 1'b1;
         OFF_RUN_MODE_CLOCK_CONFIG:      is_mapped = 1'b1;
         OFF_RUN_PORT_CLOCK_GATE:        is_mapped = 1'b1;
         OFF_SLEEP_PORT_CLOCK_GATE:      is_mapped = 1'b1;
         OFF_DEEP_SLEEP_PORT_CLOCK_GATE: is_mapped = 1'b1;
         default:                        is_mapped = 1'b0;
      endcase
   endfunction

   // write address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         wr_addr_held  <= 1'b0;
         wr_addr       <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr       <= s_axi_awaddr;
            wr_addr_held  <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            wr_addr_held  <= 1'b0;
         end else begin
            s_axi_awready <= !wr_addr_held && !s_axi_bvalid;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         wr_data_held <= 1'b0;
         wr_data      <= '0;
         wr_strb      <= '0;
      end else begin
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
            wr_data_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (wr_fire) begin
            wr_data_held <= 1'b0;
         end else begin
            s_axi_wready <= !wr_data_held && !s_axi_bvalid;
         end
      end
   end

   assign wr_fire = wr_addr_held && wr_data_held && !s_axi_bvalid;
   assign wr_hit  = is_mapped(wr_addr);

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // software reset register: capability bits that are zero clear the matching write mask bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         software_reset_ctrl_0 <= SW_RESET_RESET; // [R11]
      end else if (wr_fire && wr_addr == OFF_SOFTWARE_RESET_CTRL_0) begin
         software_reset_ctrl_0 <= merge_write(software_reset_ctrl_0, wr_data, wr_strb,
                                              SW_RESET_WMASK & device_capabilities_first);
         // [R8] [R9] [R10]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_mode_clock_config <= RUN_CFG_RESET;
      end else if (wr_fire && wr_addr == OFF_RUN_MODE_CLOCK_CONFIG) begin
         run_mode_clock_config <= merge_write(run_mode_clock_config, wr_data, wr_strb,
                                              RUN_CFG_WMASK);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_port_clock_gate <= PORT_GATE_RESET;
      end else if (wr_fire && wr_addr == OFF_RUN_PORT_CLOCK_GATE) begin
         run_port_clock_gate <= merge_write(run_port_clock_gate, wr_data, wr_strb,
                                            PORT_GATE_WMASK); // [R4]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sleep_port_clock_gate <= PORT_GATE_RESET;
      end else if (wr_fire && wr_addr == OFF_SLEEP_PORT_CLOCK_GATE) begin
         sleep_port_clock_gate <= merge_write(sleep_port_clock_gate, wr_data, wr_strb,
                                              PORT_GATE_WMASK); // [R4]
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         deep_sleep_port_clock_gate <= PORT_GATE_RESET; // [R3]
      end else if (wr_fire && wr_addr == OFF_DEEP_SLEEP_PORT_CLOCK_GATE) begin
         deep_sleep_port_clock_gate <= merge_write(deep_sleep_port_clock_gate, wr_data,
                                                   wr_strb, PORT_GATE_WMASK); // [R1] [R6]
      end
   end

   // read mux; reserved bits are never stored, so they read zero
   always_comb begin
      rd_value = '0;
      case (s_axi_araddr)
         OFF_SOFTWARE_RESET_CTRL_0:      rd_value = software_reset_ctrl_0;      // [R10]
         OFF_RUN_MODE_CLOCK_CONFIG:      rd_value = run_mode_clock_config;
         OFF_RUN_PORT_CLOCK_GATE:        rd_value = run_port_clock_gate;
         OFF_SLEEP_PORT_CLOCK_GATE:      rd_value = sleep_port_clock_gate;
         OFF_DEEP_SLEEP_PORT_CLOCK_GATE: rd_value = deep_sleep_port_clock_gate; // [R6]
         default:                        rd_value = '0;
      endcase
   end

   assign rd_hit  = is_mapped(s_axi_araddr);
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   // arready drops while a read answer is pending, so one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid || s_axi_rready;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else begin
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_value;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // effective per-port clock enables for the current power mode
   dsg_mode_gate #(
      .PORT_N      (PORT_N)
   ) u_mode_gate (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .power_mode  (power_mode),
      .auto_gating (run_mode_clock_config[AUTO_CLOCK_GATING_SELECT]),
      .run_gate    (run_port_clock_gate[PORT_N-1:0]),
      .sleep_gate  (sleep_port_clock_gate[PORT_N-1:0]),
      .deep_gate   (deep_sleep_port_clock_gate[PORT_N-1:0]),
      .port_clk_en (port_clk_en)
   );

   // a gated port cannot answer, so its access turns into a fault pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_access_fault <= '0;
      end else begin
         port_access_fault <= port_access_req & ~port_clk_en; // [R2]
      end
   end

   // unit reset holds follow the register bits one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         adc0_reset_hold     <= 1'b0;
         watchdog_reset_hold <= 1'b0;
      end else begin
         adc0_reset_hold     <= software_reset_ctrl_0[ADC0_RESET_CTRL];     // [R12] [R9]
         watchdog_reset_hold <= software_reset_ctrl_0[WATCHDOG_RESET_CTRL]; // [R12] [R10]
      end
   end

endmodule

// file: verif/dsg_ctrl_monitor.sv
// concurrent checks on the port gating and software reset slice
`timescale 1ns/1ns
module dsg_ctrl_monitor #(
   parameter int PORT_N = 5
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire logic [PORT_N-1:0] port_access_req,
   input wire logic [PORT_N-1:0] port_clk_en,
   input wire logic [PORT_N-1:0] port_access_fault,
   input wire logic              adc0_reset_hold,
   input wire logic              watchdog_reset_hold
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   wr_answer_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response late or early");
   rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data not one cycle after take");
   aw_block_a: assert property (wr_taken |=> !s_axi_awready [*2])
      else $error("write address accepted while busy");
   ar_block_a: assert property (rd_taken |=> !s_axi_arready)
      else $error("read address accepted while busy");
   gate_reset_a: assert property ($rose(aresetn) |->
      port_clk_en == '0 ##1 port_clk_en == '0)
      else $error("port enables not clear after reset");
   hold_reset_a: assert property ($rose(aresetn) |->
      !adc0_reset_hold && !watchdog_reset_hold)
      else $error("unit held in reset after system reset");
   fault_pulse_a: assert property (1'b1 |=>
      port_access_fault == ($past(port_access_req) & ~$past(port_clk_en)))
      else $error("fault does not match gated access");
   adc_follow_a: assert property ($changed(adc0_reset_hold) |-> $past(s_axi_bvalid))
      else $error("converter hold changed without a write");
   wdt_follow_a: assert property ($changed(watchdog_reset_hold) |-> $past(s_axi_bvalid))
      else $error("watchdog hold changed without a write");
endmodule

// file: verif/dsg_ctrl_tb.sv
// self-checking bench for the gating and software reset slice
`timescale 1ns/1ns
module dsg_ctrl_tb;
   import dsg_pkg::*;
   logic                  aclk, aresetn;
   logic [ADDR_W-1:0]     s_axi_awaddr, s_axi_araddr;
   logic [2:0]            s_axi_awprot, s_axi_arprot;
   logic [DATA_W-1:0]     s_axi_wdata, s_axi_rdata, device_capabilities_first, rd;
   logic [STRB_W-1:0]     s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                  s_axi_rvalid, s_axi_rready, adc0_reset_hold, watchdog_reset_hold;
   logic [PORT_N-1:0]     port_access_req, port_clk_en, port_access_fault;
   dsg_power_mode_t       power_mode;
   int                    error_cnt = 0;
   int                    n_tests = 0;

   dsg_ctrl dut (
      .aclk                      (aclk),
      .aresetn                   (aresetn),
      .s_axi_awaddr              (s_axi_awaddr),
      .s_axi_awprot              (s_axi_awprot),
      .s_axi_awvalid             (s_axi_awvalid),
      .s_axi_awready             (s_axi_awready),
      .s_axi_wdata               (s_axi_wdata),
      .s_axi_wstrb               (s_axi_wstrb),
      .s_axi_wvalid              (s_axi_wvalid),
      .s_axi_wready              (s_axi_wready),
      .s_axi_bresp               (s_axi_bresp),
      .s_axi_bvalid              (s_axi_bvalid),
      .s_axi_bready              (s_axi_bready),
      .s_axi_araddr              (s_axi_araddr),
      .s_axi_arprot              (s_axi_arprot),
      .s_axi_arvalid             (s_axi_arvalid),
      .s_axi_arready             (s_axi_arready),
      .s_axi_rdata               (s_axi_rdata),
      .s_axi_rresp               (s_axi_rresp),
      .s_axi_rvalid              (s_axi_rvalid),
      .s_axi_rready              (s_axi_rready),
      .power_mode                (power_mode),
      .device_capabilities_first (device_capabilities_first),
      .port_access_req           (port_access_req),
      .port_clk_en               (port_clk_en),
      .port_access_fault         (port_access_fault),
      .adc0_reset_hold           (adc0_reset_hold),
      .watchdog_reset_hold       (watchdog_reset_hold)
   );

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // sampling at the falling edge sees what the next rising edge will take
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic ta, tw, tb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      s_axi_bready <= 1'b0;
      chk(32'(rsp), 32'(er));
   endtask

   task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta, tr;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ta = s_axi_arready;
         tr = s_axi_rvalid;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
      s_axi_rready <= 1'b0;
      chk(rd, e);
      chk(32'(rsp), 32'(er));
   endtask

   task automatic mode(input dsg_power_mode_t m, input logic [4:0] e);
      @(posedge aclk);
      power_mode <= m;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk(32'(port_clk_en), 32'(e));
   endtask

   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = '0;
      power_mode = DSG_RUN;
      device_capabilities_first = 32'hFFFFFFFF;
      port_access_req = '0;
      do_reset();
      rdx(OFF_DEEP_SLEEP_PORT_CLOCK_GATE, 32'h0, RESP_OKAY);
      rdx(OFF_SOFTWARE_RESET_CTRL_0, 32'h0, RESP_OKAY);
      @(negedge aclk);
      chk(32'(port_clk_en), 32'h0);
      wr(OFF_DEEP_SLEEP_PORT_CLOCK_GATE, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      rdx(OFF_DEEP_SLEEP_PORT_CLOCK_GATE, 32'h1F, RESP_OKAY);
      wr(OFF_SLEEP_PORT_CLOCK_GATE, 32'h0A, 4'hF, RESP_OKAY);
      wr(OFF_RUN_PORT_CLOCK_GATE, 32'h05, 4'hF, RESP_OKAY);
      // without auto gating every mode must fall back to the run set
      mode(DSG_RUN, 5'h05);
      mode(DSG_SLEEP, 5'h05);
      mode(DSG_DEEP, 5'h05);
      wr(OFF_RUN_MODE_CLOCK_CONFIG, 32'h1, 4'hF, RESP_OKAY);
      mode(DSG_SLEEP, 5'h0A);
      mode(DSG_DEEP, 5'h1F);
      mode(DSG_RUN, 5'h05);
      // the spare mode code must fall back to the run set as well
      mode(dsg_power_mode_t'(2'h3), 5'h05);
      for (int i = 0; i < PORT_N; i++) begin
         wr(OFF_DEEP_SLEEP_PORT_CLOCK_GATE, 32'h1 << i, 4'hF, RESP_OKAY);
         mode(DSG_DEEP, 5'h1 << i);
      end
      @(posedge aclk);
      port_access_req <= 5'h1F;
      @(posedge aclk);
      port_access_req <= 5'h00;
      @(negedge aclk);
      chk(32'(port_access_fault), 32'h0F);
      @(negedge aclk);
      chk(32'(port_access_fault), 32'h0);
      // read-modify-write that hands the reserved bits back as read
      rdx(OFF_DEEP_SLEEP_PORT_CLOCK_GATE, 32'h10, RESP_OKAY);
      wr(OFF_DEEP_SLEEP_PORT_CLOCK_GATE, rd | 32'h1, 4'hF, RESP_OKAY);
      rdx(OFF_DEEP_SLEEP_PORT_CLOCK_GATE, 32'h11, RESP_OKAY);
      wr(OFF_SOFTWARE_RESET_CTRL_0, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      rdx(OFF_SOFTWARE_RESET_CTRL_0, 32'h00010008, RESP_OKAY);
      @(negedge aclk);
      chk({30'h0, adc0_reset_hold, watchdog_reset_hold}, 32'h3);
      // low byte only: bit 16 must survive the merge
      wr(OFF_SOFTWARE_RESET_CTRL_0, 32'h0, 4'h1, RESP_OKAY);
      rdx(OFF_SOFTWARE_RESET_CTRL_0, 32'h00010000, RESP_OKAY);
      device_capabilities_first <= 32'h00000008;
      @(negedge aclk);
      chk({30'h0, adc0_reset_hold, watchdog_reset_hold}, 32'h2);
      wr(OFF_SOFTWARE_RESET_CTRL_0, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      rdx(OFF_SOFTWARE_RESET_CTRL_0, 32'h00000008, RESP_OKAY);
      @(negedge aclk);
      chk({30'h0, adc0_reset_hold, watchdog_reset_hold}, 32'h1);
      rdx(12'h044, 32'h0, RESP_SLVERR);
      wr(12'h044, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
      do_reset();
      rdx(OFF_SOFTWARE_RESET_CTRL_0, 32'h0, RESP_OKAY);
      rdx(OFF_DEEP_SLEEP_PORT_CLOCK_GATE, 32'h0, RESP_OKAY);
      @(negedge aclk);
      chk({30'h0, adc0_reset_hold, watchdog_reset_hold}, 32'h0);
      end_of_test();
   end

   initial begin
      #(40 * 5000);
      error_cnt++;
      end_of_test();
   end
endmodule

bind dsg_ctrl dsg_ctrl_monitor #(
   .PORT_N (PORT_N)
) mon (
   .aclk                (aclk),
   .aresetn             (aresetn),
   .s_axi_awvalid       (s_axi_awvalid),
   .s_axi_awready       (s_axi_awready),
   .s_axi_wvalid        (s_axi_wvalid),
   .s_axi_wready        (s_axi_wready),
   .s_axi_bvalid        (s_axi_bvalid),
   .s_axi_arvalid       (s_axi_arvalid),
   .s_axi_arready       (s_axi_arready),
   .s_axi_rvalid        (s_axi_rvalid),
   .port_access_req     (port_access_req),
   .port_clk_en         (port_clk_en),
   .port_access_fault   (port_access_fault),
   .adc0_reset_hold     (adc0_reset_hold),
   .watchdog_reset_hold (watchdog_reset_hold)
);
